// ==== rtl/sdcd_device.sv ====
// What this block does
// - Low select, other strobes high means no-operation
// - No-operation lets a running burst finish
// - High select acts as no-operation
// - Controller drives clock enable as requested, one clock late
// - Clock enable low during burst, or bank active with a command, suspends
// - Suspend and resume each one clock late
// - Commands ignored while clock is suspended
// - All inputs except SYS_RST sampled on rising clock edge; SYS_RST resets asynchronously
// - Commands qualified by previous enable; refresh also by current
// - Read or write only to active bank
// - Burst stop legal only in full page
// - Enable falling with no-operation enters power-down
// - Power-down attempt during burst gives suspend
// - Enable rising with no-operation leaves power-down
// - Refresh with enable falling and all banks idle enters self-refresh
// - Suspend follows enable edges, inputs ignored
`timescale 1ns/1ps
module sdcd_device
(
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   sdcd_if.dev SD,
   output logic [sdcd_pkg::BANKS-1:0] BANK_OPEN,
   output logic BURST_BUSY,
   output logic SUSPENDED,
   output logic POWER_DOWN,
   output logic SELF_REFRESH,
   output logic WRITE_DATA_EN,
   output logic OUTPUT_EN,
   output logic ILLEGAL_CMD,
   output logic REFRESH_DONE,
   output sdcd_pkg::sdcd_cmd_t LAST_CMD
);

   // ==========================================
   // Command decode
   sdcd_pkg::sdcd_cmd_t cmd;
   logic nopish;
   logic [sdcd_pkg::BANK_W-1:0] bank_sel;
   logic ap;

   sdcd_decode u_decode
   (
      .cs_n(SD.cs_n),
      .ras_n(SD.ras_n),
      .cas_n(SD.cas_n),
      .we_n(SD.we_n),
      .cmd(cmd)
   );

   assign nopish = (cmd == sdcd_pkg::CMD_NOP) || (cmd == sdcd_pkg::CMD_DESEL);
   assign bank_sel = {SD.bank_select_high, SD.bank_select_low};
   assign ap = SD.addr[sdcd_pkg::AP_BIT];

   // ==========================================
   // State
   sdcd_pkg::sdcd_mode_t mode_r, mode_nxt;
   logic cke_prev_r, cke_prev_nxt;
   logic [sdcd_pkg::BANKS-1:0] bank_r, bank_nxt;
   logic [sdcd_pkg::BL_W-1:0] bl_r, bl_nxt;
   logic burst_r, burst_nxt;
   logic [sdcd_pkg::BURST_W-1:0] rem_r, rem_nxt;
   logic [sdcd_pkg::BANK_W-1:0] bbank_r, bbank_nxt;
   logic bwr_r, bwr_nxt;
   logic bap_r, bap_nxt;
   logic bfull_r, bfull_nxt;
   logic wde_r, wde_nxt;
   logic oen_r, oen_nxt;
   logic ill_r, ill_nxt;
   logic ref_r, ref_nxt;
   sdcd_pkg::sdcd_cmd_t last_r, last_nxt;

   logic accept;
   logic any_open;

   assign any_open = |bank_r;
   // Both enable samples high and clock running
   assign accept = (mode_r == sdcd_pkg::MODE_NORMAL) && cke_prev_r && SD.cke;

   // ==========================================
   // Next state
   always_comb
   begin
      mode_nxt = mode_r;
      cke_prev_nxt = SD.cke;
      bank_nxt = bank_r;
      bl_nxt = bl_r;
      burst_nxt = burst_r;
      rem_nxt = rem_r;
      bbank_nxt = bbank_r;
      bwr_nxt = bwr_r;
      bap_nxt = bap_r;
      bfull_nxt = bfull_r;
      ill_nxt = 1'b0;
      ref_nxt = 1'b0;
      last_nxt = last_r;

      // Fixed-length burst advances unless clock already suspended
      if (burst_r && !bfull_r && (mode_r != sdcd_pkg::MODE_SUSPEND))
      begin
         rem_nxt = rem_r - sdcd_pkg::BURST_ONE;
         if (rem_r == sdcd_pkg::BURST_ONE)
         begin
            burst_nxt = 1'b0;
            if (bap_r)
               bank_nxt[bbank_r] = 1'b0;
         end
      end

      if (accept || ((mode_r == sdcd_pkg::MODE_NORMAL) && cke_prev_r))
      begin
         last_nxt = cmd;
         unique case (cmd)
            sdcd_pkg::CMD_DESEL, sdcd_pkg::CMD_NOP:
            begin
               // Running burst left alone
            end
            sdcd_pkg::CMD_ACT:
               if (bank_r[bank_sel])
                  ill_nxt = 1'b1;
               else
                  bank_nxt[bank_sel] = 1'b1;
            sdcd_pkg::CMD_PRE:
               if (burst_r && bap_r)
                  ill_nxt = 1'b1;
               else if (ap)
               begin
                  bank_nxt = sdcd_pkg::BANKS_RST;
                  burst_nxt = 1'b0;
               end
               else
               begin
                  bank_nxt[bank_sel] = 1'b0;
                  if (bbank_r == bank_sel)
                     burst_nxt = 1'b0;
               end
            sdcd_pkg::CMD_READ, sdcd_pkg::CMD_WRITE:
               if (!bank_r[bank_sel] || (burst_r && bap_r) || (ap && (bl_r == sdcd_pkg::BL_FULL)))
                  ill_nxt = 1'b1;
               else
               begin
                  burst_nxt = 1'b1;
                  rem_nxt = sdcd_pkg::sdcd_burst_len(bl_r);
                  bbank_nxt = bank_sel;
                  bwr_nxt = (cmd == sdcd_pkg::CMD_WRITE);
                  bap_nxt = ap;
                  bfull_nxt = (bl_r == sdcd_pkg::BL_FULL);
               end
            sdcd_pkg::CMD_BST:
               if (burst_r && bfull_r)
                  burst_nxt = 1'b0;
               else
                  ill_nxt = 1'b1;
            sdcd_pkg::CMD_MRS:
               if (any_open)
                  ill_nxt = 1'b1;
               else
                  bl_nxt = SD.addr[sdcd_pkg::BL_LSB +: sdcd_pkg::BL_W];
            sdcd_pkg::CMD_REF:
               if (any_open)
                  ill_nxt = 1'b1;
               else if (SD.cke)
                  ref_nxt = 1'b1;
         endcase
      end

      // Clock enable edges against the previous sample
      unique case (mode_r)
         sdcd_pkg::MODE_NORMAL:
            if (cke_prev_r && !SD.cke)
            begin
               if (burst_r)
                  mode_nxt = sdcd_pkg::MODE_SUSPEND;
               else if (any_open)
                  mode_nxt = nopish ? sdcd_pkg::MODE_PDOWN : sdcd_pkg::MODE_SUSPEND;
               else if (cmd == sdcd_pkg::CMD_REF)
                  mode_nxt = sdcd_pkg::MODE_SREF;
               else if (nopish)
                  mode_nxt = sdcd_pkg::MODE_PDOWN;
            end
         sdcd_pkg::MODE_SUSPEND:
            if (!cke_prev_r && SD.cke)
               mode_nxt = sdcd_pkg::MODE_NORMAL;
         sdcd_pkg::MODE_PDOWN, sdcd_pkg::MODE_SREF:
            if (!cke_prev_r && SD.cke && nopish)
               mode_nxt = sdcd_pkg::MODE_NORMAL;
      endcase

      // Mask gates data paths of an active bank
      wde_nxt = burst_nxt && bwr_nxt && bank_nxt[bbank_nxt] && !SD.dqm
         && (mode_nxt == sdcd_pkg::MODE_NORMAL);
      oen_nxt = burst_nxt && !bwr_nxt && bank_nxt[bbank_nxt] && !SD.dqm
         && (mode_nxt == sdcd_pkg::MODE_NORMAL);
   end

   // ==========================================
   // Registers, sampled on rising edge only
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         mode_r <= sdcd_pkg::MODE_NORMAL;
         cke_prev_r <= 1'b1;
         bank_r <= sdcd_pkg::BANKS_RST;
         bl_r <= sdcd_pkg::BL_RST;
         burst_r <= 1'b0;
         rem_r <= sdcd_pkg::BURST_RST;
         bbank_r <= '0;
         bwr_r <= 1'b0;
         bap_r <= 1'b0;
         bfull_r <= 1'b0;
         wde_r <= 1'b0;
         oen_r <= 1'b0;
         ill_r <= 1'b0;
         ref_r <= 1'b0;
         last_r <= sdcd_pkg::CMD_DESEL;
         SUSPENDED <= 1'b0;
         POWER_DOWN <= 1'b0;
         SELF_REFRESH <= 1'b0;
      end
      else
      begin
         mode_r <= mode_nxt;
         cke_prev_r <= cke_prev_nxt;
         bank_r <= bank_nxt;
         bl_r <= bl_nxt;
         burst_r <= burst_nxt;
         rem_r <= rem_nxt;
         bbank_r <= bbank_nxt;
         bwr_r <= bwr_nxt;
         bap_r <= bap_nxt;
         bfull_r <= bfull_nxt;
         wde_r <= wde_nxt;
         oen_r <= oen_nxt;
         ill_r <= ill_nxt;
         ref_r <= ref_nxt;
         last_r <= last_nxt;
         SUSPENDED <= (mode_nxt == sdcd_pkg::MODE_SUSPEND);
         POWER_DOWN <= (mode_nxt == sdcd_pkg::MODE_PDOWN);
         SELF_REFRESH <= (mode_nxt == sdcd_pkg::MODE_SREF);
      end
   end

   assign BANK_OPEN = bank_r;
   assign BURST_BUSY = burst_r;
   assign WRITE_DATA_EN = wde_r;
   assign OUTPUT_EN = oen_r;
   assign ILLEGAL_CMD = ill_r;
   assign REFRESH_DONE = ref_r;
   assign LAST_CMD = last_r;

endmodule

// ==== common/sdcd_pkg.sv ====
package sdcd_pkg;

   // ==========================================
   // Widths and field positions
   localparam int ADDR_W = 12;
   localparam int BANKS = 4;
   localparam int BANK_W = 2;
   localparam int AP_BIT = 10;
   localparam int BL_LSB = 0;
   localparam int BL_W = 3;
   localparam int BURST_W = 4;

   // ==========================================
   // Burst length codes and reset values
   localparam logic [BL_W-1:0] BL_FULL = 3'h7;
   localparam logic [BL_W-1:0] BL_RST = 3'h0;
   localparam logic [BANKS-1:0] BANKS_RST = 4'h0;
   localparam logic [BURST_W-1:0] BURST_RST = 4'h0;
   localparam logic [BURST_W-1:0] BURST_ONE = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;

   // ==========================================
   // Commands and device modes
   typedef enum logic [3:0]
   {
      CMD_DESEL, CMD_NOP, CMD_ACT, CMD_PRE, CMD_READ,
      CMD_WRITE, CMD_BST, CMD_MRS, CMD_REF
   } sdcd_cmd_t;

   typedef enum logic [1:0]
   {
      MODE_NORMAL, MODE_SUSPEND, MODE_PDOWN, MODE_SREF
   } sdcd_mode_t;

   typedef struct packed
   {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } sdcd_pins_t;

   // Pin levels for each command
   function automatic sdcd_pins_t sdcd_encode(sdcd_cmd_t c);
      sdcd_pins_t p;
      p = 4'hF;
      unique case (c)
         CMD_DESEL: p = 4'hF;
         CMD_NOP: p = 4'h7;
         CMD_ACT: p = 4'h3;
         CMD_PRE: p = 4'h2;
         CMD_READ: p = 4'h5;
         CMD_WRITE: p = 4'h4;
         CMD_BST: p = 4'h6;
         CMD_MRS: p = 4'h0;
         CMD_REF: p = 4'h1;
         default: p = 4'hF;
      endcase
      return p;
   endfunction

   // Beats per burst code; full page reads as zero
   function automatic logic [BURST_W-1:0] sdcd_burst_len(logic [BL_W-1:0] code);
      logic [BURST_W-1:0] n;
      n = 4'h0;
      unique case (code)
         3'h0: n = 4'h1;
         3'h1: n = 4'h2;
         3'h2: n = 4'h4;
         3'h3: n = 4'h8;
         default: n = 4'h0;
      endcase
      return n;
   endfunction

endpackage

// ==== common/sdcd_if.sv ====
`timescale 1ns/1ps
interface sdcd_if;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic cke;
   logic dqm;
   logic bank_select_low;
   logic bank_select_high;
   logic [sdcd_pkg::ADDR_W-1:0] addr;

   modport ctrl
   (
      output cs_n, ras_n, cas_n, we_n, cke, dqm,
      output bank_select_low, bank_select_high, addr
   );

   modport dev
   (
      input cs_n, ras_n, cas_n, we_n, cke, dqm,
      input bank_select_low, bank_select_high, addr
   );
endinterface

// ==== rtl/sdcd_decode.sv ====
`timescale 1ns/1ps
module sdcd_decode
(
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   output sdcd_pkg::sdcd_cmd_t cmd
);

   always_comb
   begin
      cmd = sdcd_pkg::CMD_DESEL;
      if (cs_n)
      begin
         cmd = sdcd_pkg::CMD_DESEL;
      end
      else
      begin
         unique case ({ras_n, cas_n, we_n})
            3'h7: cmd = sdcd_pkg::CMD_NOP;
            3'h3: cmd = sdcd_pkg::CMD_ACT;
            3'h2: cmd = sdcd_pkg::CMD_PRE;
            3'h5: cmd = sdcd_pkg::CMD_READ;
            3'h4: cmd = sdcd_pkg::CMD_WRITE;
            3'h6: cmd = sdcd_pkg::CMD_BST;
            3'h0: cmd = sdcd_pkg::CMD_MRS;
            3'h1: cmd = sdcd_pkg::CMD_REF;
         endcase
      end
   end

endmodule

// ==== rtl/sdcd_ctrl.sv ====
`timescale 1ns/1ps
module sdcd_ctrl
(
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic REQ_VALID,
   input wire sdcd_pkg::sdcd_cmd_t REQ_CMD,
   input wire logic [sdcd_pkg::BANK_W-1:0] REQ_BANK,
   input wire logic [sdcd_pkg::ADDR_W-1:0] REQ_ADDR,
   input wire logic REQ_DQM,
   input wire logic REQ_CKE,
   output logic REQ_REJECT,
   sdcd_if.ctrl SD
);

   // ==========================================
   // Legality tracking
   logic [sdcd_pkg::BANKS-1:0] open_r, open_nxt;
   logic full_r, full_nxt;
   logic fburst_r, fburst_nxt;
   logic rej_nxt;
   logic ok;
   sdcd_pkg::sdcd_pins_t pins_nxt, pins_r;
   logic [sdcd_pkg::ADDR_W-1:0] addr_nxt, addr_r;
   logic [sdcd_pkg::BANK_W-1:0] bank_nxt, bank_r;
   logic cke_r, dqm_r;

   always_comb
   begin
      open_nxt = open_r;
      full_nxt = full_r;
      fburst_nxt = fburst_r;
      ok = 1'b1;
      pins_nxt = sdcd_pkg::sdcd_encode(sdcd_pkg::CMD_NOP);
      addr_nxt = addr_r;
      bank_nxt = bank_r;
      if (REQ_VALID)
      begin
         unique case (REQ_CMD)
            sdcd_pkg::CMD_ACT: ok = !open_r[REQ_BANK];
            sdcd_pkg::CMD_READ, sdcd_pkg::CMD_WRITE:
               ok = open_r[REQ_BANK] && !(REQ_ADDR[sdcd_pkg::AP_BIT] && full_r);
            sdcd_pkg::CMD_BST: ok = fburst_r;
            sdcd_pkg::CMD_MRS, sdcd_pkg::CMD_REF: ok = (open_r == sdcd_pkg::BANKS_RST);
            default: ok = 1'b1;
         endcase
         if (ok)
         begin
            pins_nxt = sdcd_pkg::sdcd_encode(REQ_CMD);
            addr_nxt = REQ_ADDR;
            bank_nxt = REQ_BANK;
            unique case (REQ_CMD)
               sdcd_pkg::CMD_ACT: open_nxt[REQ_BANK] = 1'b1;
               sdcd_pkg::CMD_PRE:
               begin
                  if (REQ_ADDR[sdcd_pkg::AP_BIT])
                  begin
                     open_nxt = sdcd_pkg::BANKS_RST;
                  end
                  else
                  begin
                     open_nxt[REQ_BANK] = 1'b0;
                  end
                  fburst_nxt = 1'b0;
               end
               sdcd_pkg::CMD_READ, sdcd_pkg::CMD_WRITE: fburst_nxt = full_r;
               sdcd_pkg::CMD_BST: fburst_nxt = 1'b0;
               sdcd_pkg::CMD_MRS:
                  full_nxt = (REQ_ADDR[sdcd_pkg::BL_LSB +: sdcd_pkg::BL_W] == sdcd_pkg::BL_FULL);
               default: fburst_nxt = fburst_r;
            endcase
         end
      end
      rej_nxt = REQ_VALID && !ok;
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         open_r <= sdcd_pkg::BANKS_RST;
         full_r <= 1'b0;
         fburst_r <= 1'b0;
         pins_r <= sdcd_pkg::sdcd_encode(sdcd_pkg::CMD_DESEL);
         addr_r <= sdcd_pkg::ADDR_RST;
         bank_r <= '0;
         cke_r <= 1'b1;
         dqm_r <= 1'b1;
         REQ_REJECT <= 1'b0;
      end
      else
      begin
         open_r <= open_nxt;
         full_r <= full_nxt;
         fburst_r <= fburst_nxt;
         pins_r <= pins_nxt;
         addr_r <= addr_nxt;
         bank_r <= bank_nxt;
         cke_r <= REQ_CKE;
         dqm_r <= REQ_DQM;
         REQ_REJECT <= rej_nxt;
      end
   end

   assign SD.cs_n = pins_r.cs_n;
   assign SD.ras_n = pins_r.ras_n;
   assign SD.cas_n = pins_r.cas_n;
   assign SD.we_n = pins_r.we_n;
   assign SD.cke = cke_r;
   assign SD.dqm = dqm_r;
   assign SD.addr = addr_r;
   assign SD.bank_select_low = bank_r[0];
   assign SD.bank_select_high = bank_r[1];

endmodule

// ==== verification/sdcd_properties.sv ====
`timescale 1ns/1ps
module sdcd_properties
(
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic cke,
   input wire logic dqm,
   input wire logic bank_select_low,
   input wire logic bank_select_high,
   input wire logic [sdcd_pkg::ADDR_W-1:0] addr,
   input wire logic [sdcd_pkg::BANKS-1:0] BANK_OPEN,
   input wire logic BURST_BUSY,
   input wire logic SUSPENDED,
   input wire logic POWER_DOWN,
   input wire logic SELF_REFRESH,
   input wire logic WRITE_DATA_EN,
   input wire logic OUTPUT_EN,
   input wire logic ILLEGAL_CMD,
   input wire logic REFRESH_DONE
);
   // ==========================================
   // Helper decode
   wire logic idle_enc = cs_n || (ras_n && cas_n && we_n);
   wire logic ref_enc = !cs_n && !ras_n && !cas_n && we_n;
   wire logic norm = !SUSPENDED && !POWER_DOWN && !SELF_REFRESH;
   wire logic [1:0] bank = {bank_select_high, bank_select_low};

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   // ==========================================
   // Assertions
   chk_refresh_pulse: assert property (
      (ref_enc && cke && $past(cke) && norm && BANK_OPEN == 4'h0) |=> REFRESH_DONE)
      else $error("auto refresh not acknowledged");
   chk_act_opens: assert property (
      (!cs_n && !ras_n && cas_n && we_n && cke && $past(cke) && norm && !BANK_OPEN[bank])
      |=> BANK_OPEN[$past(bank)])
      else $error("activate did not open bank");
   chk_pre_all: assert property (
      (!cs_n && !ras_n && cas_n && !we_n && addr[sdcd_pkg::AP_BIT] && cke && $past(cke) && norm)
      |=> (BANK_OPEN == 4'h0) || ILLEGAL_CMD)
      else $error("precharge all left a bank open");
   chk_bst_stops: assert property (
      (!cs_n && ras_n && cas_n && !we_n && cke && $past(cke) && norm && BURST_BUSY)
      |=> !BURST_BUSY || ILLEGAL_CMD)
      else $error("burst stop ignored");
   chk_suspend_entry: assert property (
      ($past(cke) && !cke && norm && BURST_BUSY) |=> SUSPENDED)
      else $error("no suspend on enable fall in burst");
   chk_suspend_freeze: assert property (
      SUSPENDED |=> !ILLEGAL_CMD && !REFRESH_DONE && $stable(BANK_OPEN))
      else $error("command acted on while suspended");
   chk_suspend_exit: assert property (
      (SUSPENDED && cke) |=> !SUSPENDED ##1 !SUSPENDED)
      else $error("suspend not left one clock after enable high");
   chk_pdown_entry: assert property (
      ($past(cke) && !cke && idle_enc && norm && !BURST_BUSY) |=> POWER_DOWN && !SUSPENDED)
      else $error("power down not entered");
   chk_lowpower_exit: assert property (
      ((POWER_DOWN || SELF_REFRESH) && cke && !$past(cke) && idle_enc)
      |=> !POWER_DOWN && !SELF_REFRESH)
      else $error("low power mode not left");
   chk_sref_entry: assert property (
      ($past(cke) && !cke && ref_enc && norm && BANK_OPEN == 4'h0) |=> SELF_REFRESH)
      else $error("self refresh not entered");
   chk_mask_gates: assert property (
      (OUTPUT_EN || WRITE_DATA_EN) |-> !$past(dqm) && (BANK_OPEN != 4'h0))
      else $error("data path enabled while masked or idle");
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic clk;
   logic rst;
   logic req_valid;
   sdcd_pkg::sdcd_cmd_t req_cmd;
   logic [1:0] req_bank;
   logic [11:0] req_addr;
   logic req_dqm;
   logic req_cke;
   logic req_reject;
   logic rej;
   logic [3:0] bank_open;
   logic burst_busy, suspended, power_down, self_refresh;
   logic write_data_en, output_en, illegal_cmd, refresh_done;
   sdcd_pkg::sdcd_cmd_t last_cmd;
   int errors;
   int cmp_count;

   sdcd_if sd_link();

   sdcd_ctrl sdcd_ctrl_i
   (
      .CORE_CLK(clk), .SYS_RST(rst), .REQ_VALID(req_valid), .REQ_CMD(req_cmd),
      .REQ_BANK(req_bank), .REQ_ADDR(req_addr), .REQ_DQM(req_dqm), .REQ_CKE(req_cke),
      .REQ_REJECT(req_reject), .SD(sd_link)
   );

   sdcd_device sdcd_device_i
   (
      .CORE_CLK(clk), .SYS_RST(rst), .SD(sd_link), .BANK_OPEN(bank_open),
      .BURST_BUSY(burst_busy), .SUSPENDED(suspended), .POWER_DOWN(power_down),
      .SELF_REFRESH(self_refresh), .WRITE_DATA_EN(write_data_en), .OUTPUT_EN(output_en),
      .ILLEGAL_CMD(illegal_cmd), .REFRESH_DONE(refresh_done), .LAST_CMD(last_cmd)
   );

   sdcd_properties sdcd_properties_i
   (
      .CORE_CLK(clk), .SYS_RST(rst), .cs_n(sd_link.cs_n), .ras_n(sd_link.ras_n),
      .cas_n(sd_link.cas_n), .we_n(sd_link.we_n), .cke(sd_link.cke), .dqm(sd_link.dqm),
      .bank_select_low(sd_link.bank_select_low), .bank_select_high(sd_link.bank_select_high),
      .addr(sd_link.addr), .BANK_OPEN(bank_open), .BURST_BUSY(burst_busy),
      .SUSPENDED(suspended), .POWER_DOWN(power_down), .SELF_REFRESH(self_refresh),
      .WRITE_DATA_EN(write_data_en), .OUTPUT_EN(output_en), .ILLEGAL_CMD(illegal_cmd),
      .REFRESH_DONE(refresh_done)
   );

   initial clk = 1'b0;
   always #50 clk = ~clk;

   // ==========================================
   // Request and compare tasks
   task automatic send(input sdcd_pkg::sdcd_cmd_t c, input logic [1:0] b,
                       input logic [11:0] a, input logic k);
      @(negedge clk);
      req_valid = 1'b1;
      req_cmd = c;
      req_bank = b;
      req_addr = a;
      req_cke = k;
      @(negedge clk);
      rej = req_reject;
      req_valid = 1'b0;
      @(negedge clk);
   endtask

   task automatic cmp_b(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_v(input logic [3:0] got, input logic [3:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_c(input sdcd_pkg::sdcd_cmd_t got, input sdcd_pkg::sdcd_cmd_t exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      rst = 1'b1;
      req_valid = 1'b0;
      req_cmd = sdcd_pkg::CMD_NOP;
      req_bank = 2'h0;
      req_addr = 12'h000;
      req_dqm = 1'b1;
      req_cke = 1'b1;
      rej = 1'b0;
      errors = 0;
      cmp_count = 0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      cmp_v(bank_open, 4'h0);
      cmp_c(last_cmd, sdcd_pkg::CMD_DESEL);
      send(sdcd_pkg::CMD_MRS, 2'h0, 12'h002, 1'b1);
      cmp_c(last_cmd, sdcd_pkg::CMD_MRS);
      send(sdcd_pkg::CMD_REF, 2'h0, 12'h000, 1'b1);
      cmp_b(refresh_done, 1'b1);
      send(sdcd_pkg::CMD_ACT, 2'h1, 12'h000, 1'b1);
      cmp_v(bank_open, 4'h2);
      send(sdcd_pkg::CMD_ACT, 2'h1, 12'h000, 1'b1);
      cmp_b(rej, 1'b1);
      send(sdcd_pkg::CMD_READ, 2'h0, 12'h000, 1'b1);
      cmp_b(rej, 1'b1);
      req_dqm = 1'b0;
      send(sdcd_pkg::CMD_READ, 2'h1, 12'h000, 1'b1);
      cmp_b(burst_busy, 1'b1);
      cmp_b(output_en, 1'b1);
      repeat (3) @(negedge clk);
      cmp_b(burst_busy, 1'b1);
      @(negedge clk);
      cmp_b(burst_busy, 1'b0);
      req_dqm = 1'b1;
      send(sdcd_pkg::CMD_WRITE, 2'h1, 12'h000, 1'b1);
      cmp_b(burst_busy, 1'b1);
      cmp_b(write_data_en, 1'b0);
      repeat (4) @(negedge clk);
      // Enable drop in mid burst, then an ignored activate
      send(sdcd_pkg::CMD_READ, 2'h1, 12'h000, 1'b1);
      req_cke = 1'b0;
      // Enable passes the controller register, then the device edge
      repeat (2) @(negedge clk);
      cmp_b(suspended, 1'b1);
      send(sdcd_pkg::CMD_ACT, 2'h2, 12'h000, 1'b0);
      cmp_v(bank_open, 4'h2);
      cmp_b(burst_busy, 1'b1);
      req_cke = 1'b1;
      repeat (2) @(negedge clk);
      cmp_b(suspended, 1'b0);
      repeat (6) @(negedge clk);
      req_cke = 1'b0;
      repeat (2) @(negedge clk);
      cmp_b(power_down, 1'b1);
      cmp_b(suspended, 1'b0);
      req_cke = 1'b1;
      repeat (2) @(negedge clk);
      cmp_b(power_down, 1'b0);
      cmp_v(bank_open, 4'h2);
      send(sdcd_pkg::CMD_BST, 2'h1, 12'h000, 1'b1);
      cmp_b(rej, 1'b1);
      send(sdcd_pkg::CMD_PRE, 2'h0, 12'h400, 1'b1);
      cmp_v(bank_open, 4'h0);
      // Full page burst closed by burst stop
      send(sdcd_pkg::CMD_MRS, 2'h0, 12'h007, 1'b1);
      send(sdcd_pkg::CMD_ACT, 2'h3, 12'h000, 1'b1);
      send(sdcd_pkg::CMD_READ, 2'h3, 12'h400, 1'b1);
      cmp_b(rej, 1'b1);
      send(sdcd_pkg::CMD_READ, 2'h3, 12'h000, 1'b1);
      repeat (10) @(negedge clk);
      cmp_b(burst_busy, 1'b1);
      send(sdcd_pkg::CMD_BST, 2'h3, 12'h000, 1'b1);
      cmp_b(burst_busy, 1'b0);
      cmp_v(bank_open, 4'h8);
      send(sdcd_pkg::CMD_PRE, 2'h0, 12'h400, 1'b1);
      send(sdcd_pkg::CMD_REF, 2'h0, 12'h000, 1'b0);
      cmp_b(self_refresh, 1'b1);
      req_cke = 1'b1;
      repeat (2) @(negedge clk);
      cmp_b(self_refresh, 1'b0);
      // Auto-precharge write, a read refused inside it, bank closed after
      send(sdcd_pkg::CMD_MRS, 2'h0, 12'h002, 1'b1);
      send(sdcd_pkg::CMD_ACT, 2'h1, 12'h000, 1'b1);
      req_dqm = 1'b0;
      send(sdcd_pkg::CMD_WRITE, 2'h1, 12'h400, 1'b1);
      cmp_b(write_data_en, 1'b1);
      send(sdcd_pkg::CMD_READ, 2'h1, 12'h000, 1'b1);
      cmp_b(illegal_cmd, 1'b1);
      @(negedge clk);
      cmp_v(bank_open, 4'h0);
      send(sdcd_pkg::CMD_DESEL, 2'h0, 12'h000, 1'b1);
      cmp_c(last_cmd, sdcd_pkg::CMD_DESEL);
      send(sdcd_pkg::CMD_NOP, 2'h0, 12'h000, 1'b1);
      cmp_c(last_cmd, sdcd_pkg::CMD_NOP);
      close_out();
   end
endmodule
